// *** rtl/lamp_defines.svh ***
// register map, field positions, reset values and timing of the lamp block
`ifndef LAMP_DEFINES_SVH
`define LAMP_DEFINES_SVH
`define ADDR_CTRL      8'h00
`define ADDR_FAULT     8'h04
`define ADDR_PULSE     8'h08
`define ADDR_STATUS    8'h0C
`define CTRL_LOGGER    0
`define CTRL_RISING    1
`define CTRL_PULSE_EN  2
`define CTRL_HOST      3
`define CTRL_FW_ERR    4
`define CTRL_RST       5'h00
`define PULSE_RST      16'h0064
`define MCLK_NS        40
`define TICK_MS        1
`define TICK_CYC       ((`TICK_MS * 1000000) / `MCLK_NS)
`define DEBOUNCE_MS    30
`define DEBOUNCE_CYC   ((`DEBOUNCE_MS * 1000000 + `MCLK_NS - 1) / `MCLK_NS)
`define FLASH_MS       50
`define SLOW_BIT       9
`define FAST_BIT       7
`define RUN_LSB        8
`define SLOT_LSB       9
`define SLOT_ON_BIT    8
`define BEACON_LSB     7
`define DUTY_ON        10'h399
`endif

// *** rtl/lamp_link_if.sv ***
// timebase and trigger signals between the lamp block and its helpers
`timescale 1ns/10ps
interface lamp_link_if;
	logic        tick;       // one cycle per millisecond
	logic [11:0] phase;      // free-running millisecond count
	logic        rising_sel; // trigger on release from ground
	logic        fire;       // debounced trigger event
	logic        level;      // debounced trigger pin level
	modport pre_mp (output tick, phase);
	modport deb_mp (input rising_sel, output fire, level);
	modport top_mp (input tick, phase, fire, level, output rising_sel);
endinterface

// *** rtl/lamp_pkg.sv ***
// types shared by the lamp and trigger block
package lamp_pkg;
	typedef enum logic [2:0] {
		LOG_IDLE    = 3'h0,
		LOG_ARMED   = 3'h1,
		LOG_ACTIVE  = 3'h2,
		LOG_STOPPED = 3'h3,
		LOG_CLOSING = 3'h4
	} log_state_t;
	typedef enum logic [2:0] {
		FAULT_NONE      = 3'h0,
		FAULT_OVERRUN   = 3'h1,
		FAULT_DISK_FULL = 3'h2,
		FAULT_CONFIG    = 3'h3,
		FAULT_DISK_ERR  = 3'h4,
		FAULT_OTHER     = 3'h5
	} fault_t;
endpackage

// *** rtl/lamp_prescaler.sv ***
// millisecond tick and pattern phase counter
`timescale 1ns/10ps
`include "lamp_defines.svh"
module lamp_prescaler #(
	parameter int unsigned TICK_CYC = `TICK_CYC
) (
	input  wire logic        mclk,   // system clock
	input  wire logic        arst_n, // async reset, active low
	lamp_link_if.pre_mp      link    // tick and phase out
);
	typedef struct packed {
		logic [14:0] div;
		logic        tick;
		logic [11:0] phase;
	} pre_state_t;
	pre_state_t st_reg;
	pre_state_t st_next;

	// divide the clock down to one tick per millisecond
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.div == 15'(TICK_CYC - 1)) begin
			st_next.div = 15'h0000;
			st_next.tick = 1'b1;
			st_next.phase = st_reg.phase + 12'h001;
		end else begin
			st_next.div = st_reg.div + 15'h0001;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.tick = st_reg.tick;
	assign link.phase = st_reg.phase;
endmodule

// *** rtl/logger_lamps.sv ***
// lamp patterns, logging state, trigger output and apb registers
`timescale 1ns/10ps
`include "lamp_defines.svh"
module logger_lamps #(
	parameter int unsigned TICK_CYC = `TICK_CYC,
	parameter int unsigned DEB_CYC  = `DEBOUNCE_CYC
) (
	input  wire logic        mclk,                // 25 MHz clock
	input  wire logic        arst_n,              // async reset
	input  wire logic [7:0]  paddr,               // apb address
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb enable
	input  wire logic        pwrite,              // apb direction
	input  wire logic [31:0] pwdata,              // apb write data
	output logic      [31:0] prdata,              // apb read data
	output logic             pready,              // apb ready
	output logic             pslverr,             // apb error
	input  wire logic [1:0]  can_activity,        // message pulse
	input  wire logic [1:0]  can_err_frame,       // error frame pulse
	input  wire logic [1:0]  can_err_passive,     // passive level
	input  wire logic        usb_present,         // usb link up
	input  wire logic        disk_present,        // disk seated
	input  wire logic        disk_busy,           // disk formatting
	input  wire logic        trig_pin,            // trigger pin
	output logic             power_lamp,          // green lamp
	output logic             first_channel_lamp,  // yellow lamp 1
	output logic             second_channel_lamp, // yellow lamp 2
	output logic             err_red,             // error lamp red
	output logic             err_yellow,          // error lamp yellow
	output logic             trig_out,            // output pulse pin
	output logic             log_enable,          // logging running
	output logic             log_close            // close file pulse
);
	localparam logic [5:0] FLASH = 6'(`FLASH_MS / `TICK_MS);

	typedef struct packed {
		logic [4:0]          ctrl;
		lamp_pkg::fault_t    fault;
		logic [15:0]         pulse_len;
		lamp_pkg::log_state_t log;
		logic [7:0]          trig_cnt;
		logic [1:0][5:0]     fl;
		logic [5:0]          ef;
		logic [15:0]         pulse_cnt;
		logic                trig_out;
		logic                log_en;
		logic                close;
		logic [4:0]          lamp;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
	} top_state_t;
	top_state_t st_reg;
	top_state_t st_next;

	lamp_link_if link ();

	lamp_prescaler #(.TICK_CYC(TICK_CYC)) u_pre (
		.mclk   (mclk),
		.arst_n (arst_n),
		.link   (link.pre_mp)
	);

	trigger_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.trig_pin (trig_pin),
		.link     (link.deb_mp)
	);

	assign link.rising_sel = st_reg.ctrl[`CTRL_RISING];

	// blink sources cut from the millisecond phase
	logic slow;
	logic fast;
	logic duty90;
	logic beacon;
	logic code_on;
	logic [1:0] run;
	assign slow = link.phase[`SLOW_BIT];
	assign fast = link.phase[`FAST_BIT];
	assign duty90 = link.phase[9:0] < `DUTY_ON;
	assign beacon = link.phase[11:`BEACON_LSB] == 5'h00;
	assign run = link.phase[`RUN_LSB+1:`RUN_LSB];
	assign code_on = (link.phase[11:`SLOT_LSB] < st_reg.fault) &&
		link.phase[`SLOT_ON_BIT];

	// per channel flash stretcher; a new message wins over the decrement
	logic [1:0][5:0] fl_next;
	logic [1:0] chan_on;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			assign fl_next[gi] = can_activity[gi] ? FLASH :
				(link.tick && st_reg.fl[gi] != 6'h00) ?
				st_reg.fl[gi] - 6'h01 : st_reg.fl[gi];
			assign chan_on[gi] = can_err_passive[gi] ? slow :
				(fl_next[gi] != 6'h00);
		end
	endgenerate

	// error frame flash stretcher shared by both channels
	logic [5:0] ef_next;
	assign ef_next = (|can_err_frame) ? FLASH :
		(link.tick && st_reg.ef != 6'h00) ?
		st_reg.ef - 6'h01 : st_reg.ef;

	// apb phase decode
	logic setup;
	logic acc;
	logic mapped;
	assign setup = psel && !penable;
	assign acc = psel && penable && st_reg.pready;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `ADDR_STATUS);

	// next state of registers, logging fsm, pulse and lamps
	always_comb begin
		logic       pw;
		logic [1:0] ch;
		logic       red;
		logic       yel;
		logic       logger;
		pw = 1'b0;
		ch = 2'b00;
		red = 1'b0;
		yel = 1'b0;
		logger = st_reg.ctrl[`CTRL_LOGGER];
		st_next = st_reg;
		st_next.fl = fl_next;
		st_next.ef = ef_next;

		// apb: one wait state, data and error set up in the first cycle
		st_next.pready = setup;
		st_next.pslverr = setup && !mapped;
		if (setup) begin
			case (paddr)
				`ADDR_CTRL:   st_next.prdata = {27'h0000000, st_reg.ctrl};
				`ADDR_FAULT:  st_next.prdata = {29'h00000000, st_reg.fault};
				`ADDR_PULSE:  st_next.prdata = {16'h0000, st_reg.pulse_len};
				`ADDR_STATUS: st_next.prdata = {16'h0000, st_reg.trig_cnt,
					can_err_passive, disk_present, usb_present,
					link.level, st_reg.log};
				default:      st_next.prdata = 32'h00000000;
			endcase
		end
		if (acc && pwrite && !st_reg.pslverr) begin
			case (paddr)
				`ADDR_CTRL:  st_next.ctrl = pwdata[4:0];
				`ADDR_FAULT: st_next.fault = (pwdata[2:0] > 3'h5) ?
					lamp_pkg::FAULT_OTHER : lamp_pkg::fault_t'(pwdata[2:0]);
				`ADDR_PULSE: st_next.pulse_len = pwdata[15:0];
				default:     st_next.pulse_len = st_reg.pulse_len;
			endcase
		end

		// logging sequence
		unique case (st_reg.log)
			lamp_pkg::LOG_IDLE: begin
				if (logger && disk_present && !usb_present &&
					!st_reg.ctrl[`CTRL_FW_ERR] &&
					st_reg.fault == lamp_pkg::FAULT_NONE) begin
					st_next.log = lamp_pkg::LOG_ARMED;
				end
			end
			lamp_pkg::LOG_ARMED: begin
				if (usb_present || !logger) begin
					st_next.log = lamp_pkg::LOG_CLOSING;
				end else if (link.fire) begin
					st_next.log = lamp_pkg::LOG_ACTIVE;
				end
			end
			lamp_pkg::LOG_ACTIVE: begin
				if (usb_present || !logger) begin
					st_next.log = lamp_pkg::LOG_CLOSING;
				end else if (link.fire) begin
					st_next.log = lamp_pkg::LOG_STOPPED;
				end
			end
			lamp_pkg::LOG_STOPPED: begin
				if (usb_present || !logger) begin
					st_next.log = lamp_pkg::LOG_IDLE;
				end
			end
			lamp_pkg::LOG_CLOSING: begin
				st_next.log = lamp_pkg::LOG_IDLE;
			end
			default: begin
				st_next.log = lamp_pkg::LOG_IDLE;
			end
		endcase
		st_next.log_en = (st_next.log == lamp_pkg::LOG_ARMED) ||
			(st_next.log == lamp_pkg::LOG_ACTIVE);
		st_next.close = (st_next.log == lamp_pkg::LOG_CLOSING);

		// trigger events: count them and start the output pulse
		if (link.fire) begin
			st_next.trig_cnt = st_reg.trig_cnt + 8'h01;
		end
		if (link.fire && st_reg.ctrl[`CTRL_PULSE_EN]) begin
			st_next.pulse_cnt = st_reg.pulse_len;
		end else if (link.tick && st_reg.pulse_cnt != 16'h0000) begin
			st_next.pulse_cnt = st_reg.pulse_cnt - 16'h0001;
		end
		st_next.trig_out = st_next.pulse_cnt != 16'h0000;

		// lamp pattern by priority of conditions
		if (!disk_present && !usb_present) begin
			pw = slow;
			ch = {slow, slow};
			red = slow;
		end else if (st_reg.ctrl[`CTRL_HOST] && usb_present) begin
			pw = run == 2'h0;
			ch = {run == 2'h2, run == 2'h1};
			red = disk_busy ? slow : (run == 2'h3);
		end else if (st_reg.ctrl[`CTRL_FW_ERR]) begin
			pw = fast;
			red = 1'b1;
		end else if (!logger) begin
			pw = usb_present ? 1'b1 : slow;
			ch = chan_on;
			red = (|can_err_passive) && slow;
			yel = ef_next != 6'h00;
		end else if (!usb_present && st_reg.log == lamp_pkg::LOG_IDLE) begin
			pw = beacon;
		end else begin
			unique case (st_reg.log)
				lamp_pkg::LOG_ARMED:   pw = duty90;
				lamp_pkg::LOG_ACTIVE:  pw = fast;
				lamp_pkg::LOG_STOPPED: pw = slow;
				default:               pw = 1'b1;
			endcase
			ch = chan_on;
			if (st_reg.fault != lamp_pkg::FAULT_NONE) begin
				red = 1'b1;
				yel = code_on;
			end else begin
				red = (|can_err_passive) && slow;
				yel = ef_next != 6'h00;
			end
		end
		// the bi-colour lamp shows one colour at a time, yellow on top
		st_next.lamp = {yel, red && !yel, ch, pw};
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.ctrl <= `CTRL_RST;
			st_reg.pulse_len <= `PULSE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign power_lamp = st_reg.lamp[0];
	assign first_channel_lamp = st_reg.lamp[1];
	assign second_channel_lamp = st_reg.lamp[2];
	assign err_red = st_reg.lamp[3];
	assign err_yellow = st_reg.lamp[4];
	assign trig_out = st_reg.trig_out;
	assign log_enable = st_reg.log_en;
	assign log_close = st_reg.close;

	// checks on bus, sequence and lamps
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_apb_wait: assert property ((psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer not one wait state");
	a_apb_unmapped: assert property (
		(psel && !penable && !mapped) |=> pslverr && pready)
		else $error("unmapped address not flagged");
	a_usb_close: assert property (
		(st_reg.log == lamp_pkg::LOG_ACTIVE && usb_present)
		|=> log_close && !log_enable ##1 !log_close)
		else $error("usb did not close the log");
	a_auto_arm: assert property (
		(st_reg.log == lamp_pkg::LOG_IDLE && st_reg.ctrl[`CTRL_LOGGER] &&
		disk_present && !usb_present && !st_reg.ctrl[`CTRL_FW_ERR] &&
		st_reg.fault == lamp_pkg::FAULT_NONE) |=> log_enable)
		else $error("logging did not start");
	a_pulse_start: assert property (
		(link.fire && st_reg.ctrl[`CTRL_PULSE_EN] &&
		st_reg.pulse_len != 16'h0000) |=> trig_out)
		else $error("output pulse missing");
	a_fw_red: assert property (
		(st_reg.ctrl[`CTRL_FW_ERR] && disk_present &&
		!(st_reg.ctrl[`CTRL_HOST] && usb_present))
		|=> err_red && !err_yellow)
		else $error("config error lamp not red");
	a_chan_flash: assert property (
		(!st_reg.ctrl[`CTRL_LOGGER] && !st_reg.ctrl[`CTRL_FW_ERR] &&
		!st_reg.ctrl[`CTRL_HOST] && disk_present && can_activity[0] &&
		!can_err_passive[0]) |=> first_channel_lamp)
		else $error("channel flash missing");
	a_power_steady: assert property (
		(!st_reg.ctrl[`CTRL_LOGGER] && !st_reg.ctrl[`CTRL_FW_ERR] &&
		!st_reg.ctrl[`CTRL_HOST] && usb_present) |=> power_lamp)
		else $error("power lamp not steady with usb");
	a_logger_flash: assert property (
		(st_reg.log == lamp_pkg::LOG_ACTIVE && st_reg.ctrl[`CTRL_LOGGER] &&
		!st_reg.ctrl[`CTRL_FW_ERR] && disk_present && !usb_present &&
		can_activity[1] && !can_err_passive[1]) |=> second_channel_lamp)
		else $error("logger channel flash missing");
	a_one_colour: assert property (!(err_red && err_yellow))
		else $error("error lamp shows both colours");

	c_stopped: cover property (st_reg.log == lamp_pkg::LOG_ACTIVE ##1
		st_reg.log == lamp_pkg::LOG_STOPPED);
	c_close: cover property (log_close);
	c_pulse: cover property ($rose(trig_out));
	c_slverr: cover property (pslverr);
endmodule

// *** rtl/trigger_debounce.sv ***
// trigger pin synchroniser, debouncer and edge selector
`timescale 1ns/10ps
`include "lamp_defines.svh"
module trigger_debounce #(
	parameter int unsigned DEB_CYC = `DEBOUNCE_CYC
) (
	input  wire logic        mclk,     // system clock
	input  wire logic        arst_n,   // async reset, active low
	input  wire logic        trig_pin, // raw pin, pulled up
	lamp_link_if.deb_mp      link      // edge select in, event out
);
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic [19:0] cnt;
		logic        level;
		logic        fire;
	} deb_state_t;
	deb_state_t st_reg;
	deb_state_t st_next;

	// accept a new level only after it stayed stable for the full window
	always_comb begin
		st_next = st_reg;
		st_next.s1 = trig_pin;
		st_next.s2 = st_reg.s1;
		st_next.fire = 1'b0;
		if (st_reg.s2 == st_reg.level) begin
			st_next.cnt = 20'h00000;
		end else if (st_reg.cnt == 20'(DEB_CYC - 1)) begin
			st_next.cnt = 20'h00000;
			st_next.level = st_reg.s2;
			st_next.fire = (st_reg.s2 == link.rising_sel);
		end else begin
			st_next.cnt = st_reg.cnt + 20'h00001;
		end
	end

	// pin idles high through its pull-up
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, cnt: 20'h00000,
				level: 1'b1, fire: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.fire = st_reg.fire;
	assign link.level = st_reg.level;

	a_fire_level: assert property (
		@(posedge mclk) disable iff (!arst_n)
		link.fire |-> $changed(link.level) && link.level == link.rising_sel)
		else $error("trigger event without matching level change");
endmodule

// *** verif/logger_lamps_bench.sv ***
// self-checking bench for the lamp and trigger block
`timescale 1ns/10ps
`include "lamp_defines.svh"
module logger_lamps_bench;
	localparam int T = 2; // cycles per millisecond here
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic        usb_present, disk_present, disk_busy, grounded, err;
	logic        trig_pin, power_lamp, first_channel_lamp, log_close;
	logic        second_channel_lamp, err_red, err_yellow, trig_out;
	logic        log_enable;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  can_activity, can_err_frame, can_err_passive;
	logic [5:0]  lamps;
	int          errors, checks_done, st, tc, plen, seed, n;
	int          hi[6], ri[6], regm[4];

	assign lamps = {trig_out, err_yellow, err_red, second_channel_lamp,
		first_channel_lamp, power_lamp};

	logger_lamps #(.TICK_CYC(T), .DEB_CYC(20)) dut (
		.mclk(mclk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.can_activity(can_activity), .can_err_frame(can_err_frame),
		.can_err_passive(can_err_passive), .usb_present(usb_present),
		.disk_present(disk_present), .disk_busy(disk_busy),
		.trig_pin(trig_pin), .power_lamp(power_lamp),
		.first_channel_lamp(first_channel_lamp),
		.second_channel_lamp(second_channel_lamp), .err_red(err_red),
		.err_yellow(err_yellow), .trig_out(trig_out),
		.log_enable(log_enable), .log_close(log_close));

	trigger_partner sw (.mclk(mclk), .grounded(grounded),
		.trig_out(trig_out), .trig_pin(trig_pin), .plen(plen));

	// free-running clock
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	task tally_and_finish;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// a wait that ran out ends the run
	task hang;
		errors++;
		$display("mismatch at %0t: no answer in time", $time);
		tally_and_finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task rng(input int got, input int lo, input int up);
		checks_done++;
		if (got < lo || got > up) begin
			errors++;
			$display("mismatch at %0t: %0d outside %0d..%0d", $time, got,
				lo, up);
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) hang;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// write and keep the model copy of the register
	task wr(input logic [7:0] a, input int d);
		apb(1'b1, a, d);
		case (a)
			`ADDR_CTRL: regm[0] = d & 32'h1F;
			`ADDR_FAULT: regm[1] = ((d & 7) > 5) ? 5 : (d & 7);
			`ADDR_PULSE: regm[2] = d & 32'hFFFF;
			default: ;
		endcase
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
		cmp({31'h0, err}, {31'h0, ee});
	endtask
	// log state, trigger count and logging flag against the model
	task chk_status;
		apb(1'b0, `ADDR_STATUS, 32'h0);
		cmp({29'h0, rd[2:0]}, st);
		cmp({24'h0, rd[15:8]}, tc);
		cmp({31'h0, log_enable}, (st == 1 || st == 2));
	endtask
	// lit cycles and rising edges of every lamp over cyc cycles
	task meas(input int cyc);
		logic [5:0] p;
		p = lamps;
		for (int i = 0; i < 6; i++) begin
			hi[i] = 0;
			ri[i] = 0;
		end
		repeat (cyc) begin
			@(posedge mclk);
			for (int i = 0; i < 6; i++) begin
				hi[i] += (lamps[i] === 1'b1);
				ri[i] += (lamps[i] === 1'b1 && p[i] === 1'b0);
			end
			p = lamps;
		end
	endtask
	task press(input logic g, input int cyc);
		grounded <= g;
		repeat (cyc) @(posedge mclk);
	endtask

	// main sequence
	initial begin
		seed = 32'hF1D4;
		regm = '{0, 0, 32'h64, 0};
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{usb_present, disk_present, disk_busy, grounded} = '0;
		{can_activity, can_err_frame, can_err_passive} = '0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		cmp({25'h0, log_enable, lamps}, 32'h0);
		rdchk(`ADDR_CTRL, regm[0], 1'b0);
		rdchk(`ADDR_PULSE, regm[2], 1'b0);
		rdchk(8'h10, 32'h0, 1'b1);
		wr(`ADDR_FAULT, 6);
		rdchk(`ADDR_FAULT, regm[1], 1'b0);
		wr(`ADDR_FAULT, 0);
		// interface mode with the host attached
		usb_present <= 1'b1;
		disk_present <= 1'b1;
		@(posedge mclk);
		meas(200);
		rng(hi[0], 200, 200);
		can_activity <= 2'b01;
		can_err_frame <= 2'b10;
		@(posedge mclk);
		can_activity <= 2'b00;
		can_err_frame <= 2'b00;
		@(posedge mclk);
		cmp({31'h0, first_channel_lamp}, 1);
		meas(200);
		rng(hi[1], 50 * T - 6, 50 * T + 2);
		rng(hi[2], 0, 0);
		rng(hi[4], 50 * T - 6, 50 * T + 2);
		usb_present <= 1'b0;
		meas(1024 * T);
		rng(hi[0], 512 * T - 4, 512 * T + 4);
		usb_present <= 1'b1;
		can_err_passive <= 2'b01;
		meas(1024 * T);
		rng(hi[3], 400 * T, 624 * T);
		can_err_passive <= 2'b00;
		// no disk and no host: power, channel and red lamps blink, yellow stays off
		usb_present <= 1'b0;
		disk_present <= 1'b0;
		meas(1024 * T);
		for (int i = 0; i < 3; i++) begin
			rng(hi[i], 512 * T - 4, 512 * T + 4);
		end
		// host application talking, disk being formatted
		usb_present <= 1'b1;
		disk_present <= 1'b1;
		disk_busy <= 1'b1;
		wr(`ADDR_CTRL, 8);
		meas(1024 * T);
		for (int i = 0; i < 3; i++) begin
			rng(hi[i], 1, 1024 * T - 1);
		end
		rng(hi[3], 512 * T - 4, 512 * T + 4);
		disk_busy <= 1'b0;
		wr(`ADDR_CTRL, 16);
		meas(1024 * T);
		rng(hi[3], 1024 * T, 1024 * T);
		rng(ri[0], 3, 5);
		// every fault code in logger mode
		wr(`ADDR_CTRL, 1);
		for (int k = 1; k <= 5; k++) begin
			wr(`ADDR_FAULT, k);
			@(posedge mclk);
			meas(4096 * T);
			rng(ri[4], k, k);
			rng(hi[3] + hi[4], 4096 * T - 40, 4096 * T);
		end
		usb_present <= 1'b0;
		repeat (4) @(posedge mclk);
		meas(4096 * T);
		rng(hi[0], 128 * T - 4, 128 * T + 4);
		rng(hi[1] + hi[2] + hi[3] + hi[4], 0, 0);
		// fault cleared: logging arms by itself
		wr(`ADDR_FAULT, 0);
		st = 1;
		repeat (3) @(posedge mclk);
		chk_status;
		meas(1024 * T);
		rng(hi[0], 921 * T - 8, 921 * T + 8);
		wr(`ADDR_PULSE, 5);
		wr(`ADDR_CTRL, 5);
		repeat (3) begin
			press(1'b1, 2 + ($random(seed) & 7));
			press(1'b0, 30);
		end
		chk_status;
		press(1'b1, 40);
		st = 2;
		tc = 1;
		chk_status;
		rng(plen, 5 * T - T, 5 * T + T);
		// a message while logging flashes its channel lamp
		can_activity <= 2'b10;
		@(posedge mclk);
		can_activity <= 2'b00;
		@(posedge mclk);
		cmp({31'h0, second_channel_lamp}, 1);
		meas(1024 * T);
		rng(ri[0], 3, 5);
		press(1'b0, 40);
		chk_status;
		press(1'b1, 40);
		st = 3;
		tc = 2;
		chk_status;
		meas(1024 * T);
		rng(hi[0], 512 * T - 4, 512 * T + 4);
		usb_present <= 1'b1;
		repeat (4) @(posedge mclk);
		st = 0;
		chk_status;
		// rising edge selected, then the host appears mid-log
		usb_present <= 1'b0;
		wr(`ADDR_CTRL, 7);
		st = 1;
		repeat (3) @(posedge mclk);
		chk_status;
		press(1'b0, 40);
		st = 2;
		tc = 3;
		chk_status;
		usb_present <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (log_close !== 1'b1 && n < 16);
		if (log_close !== 1'b1) hang;
		cmp({31'h0, log_enable}, 0);
		@(posedge mclk);
		cmp({31'h0, log_close}, 0);
		st = 0;
		chk_status;
		tally_and_finish;
	end
endmodule

// *** verif/trigger_partner.sv ***
// trigger switch with pull-up and a meter on the output pulse
`timescale 1ns/10ps
module trigger_partner (
	input  wire logic mclk,     // system clock
	input  wire logic grounded, // switch closed to ground
	input  wire logic trig_out, // pulse from the device
	output logic      trig_pin, // pin level seen by the device
	output int        plen      // width of last pulse, cycles
);
	int run;
	// pull-up holds the pin high while the switch is open
	assign trig_pin = grounded ? 1'b0 : 1'b1;
	// measure each output pulse once it ends
	always_ff @(posedge mclk) begin
		if (trig_out === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			plen <= run;
			run <= 0;
		end
	end
endmodule
